// ===== rtl/ccu_channel.sv
// capture/compare channel with its software register port
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module ccu_channel
    import ccu_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    ccu_link_if.channel link,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdData,
    output logic wakeRequest
);
    logic [DATA_W-1:0] ctrl_q;
    logic [3:0] capSel_q;
    logic [CNT_W-1:0] hold_q;
    logic [CNT_W-1:0] hold_d;
    logic flag_q;
    logic eventEnable_q;
    logic srcNow_q;
    logic srcPrev_q;
    logic [3:0] presc_q;
    logic [3:0] presc_d;
    logic matchPrev_q;
    logic outLatch_q;
    logic outLatch_d;
    logic oeN_q;
    logic trig_q;
    logic wake_q;
    logic [DATA_W-1:0] rd_q;
    logic [DATA_W-1:0] rd_d;

    wire [3:0] mode = ctrl_q[3:0];
    wire chanOn = ctrl_q[CTRL_ON_BIT];
    wire inCapture = chanOn && isCaptureMode(mode);
    wire inCompare = chanOn && isCompareMode(mode);
    // each channel picks its own timer
    wire [CNT_W-1:0] refCount = ctrl_q[CTRL_TSEL_BIT] ? link.timerBCount : link.timerACount;

    wire wrCtrl = regWrite && (regAddr == REG_CTRL);
    wire wrCapSel = regWrite && (regAddr == REG_CAPSRC);
    wire wrHoldLo = regWrite && (regAddr == REG_HOLD_LO);
    wire wrHoldHi = regWrite && (regAddr == REG_HOLD_HI);
    wire wrFlag = regWrite && (regAddr == REG_FLAG);
    wire wrEnable = regWrite && (regAddr == REG_ENABLE);

    // pin level comes back from the wire itself, so a driven pin still captures
    wire srcSelected = (capSel_q == SRC_PIN) ? link.pinLevel :
                       ((capSel_q <= 4'(SRC_N)) ? link.capSources[3'(capSel_q - 4'h1)] : 1'b0);

    wire riseEdge = srcNow_q && !srcPrev_q;
    wire fallEdge = !srcNow_q && srcPrev_q;

    wire captureHit = inCapture && (
        ((mode == MODE_CAP_FALL) && fallEdge) ||
        ((mode == MODE_CAP_RISE) && riseEdge) ||
        ((mode == MODE_CAP_RISE4) && riseEdge && (presc_q[1:0] == PRESC_MAX4[1:0])) ||
        ((mode == MODE_CAP_RISE16) && riseEdge && (presc_q == PRESC_MAX16)));

    wire matchNow = inCompare && (hold_q == refCount);
    // acting on the rising edge of the match keeps a slow timer from re-firing the action
    wire matchRise = matchNow && !matchPrev_q;

    // prescaler only clears when leaving capture, so a direct switch keeps its count
    always_comb begin
        presc_d = presc_q;
        if (!inCapture) begin
            presc_d = 4'h0;
        end else if (riseEdge) begin
            presc_d = presc_q + 4'h1;
        end
    end

    // a capture overwrites whatever software has not yet read
    always_comb begin
        hold_d = hold_q;
        if (wrHoldLo) begin
            hold_d[DATA_W-1:0] = regWrData;
        end
        if (wrHoldHi) begin
            hold_d[CNT_W-1:DATA_W] = regWrData;
        end
        if (captureHit) begin
            hold_d = refCount;
        end
    end

    always_comb begin
        outLatch_d = outLatch_q;
        if (matchRise) begin
            case (mode)
                MODE_TOGGLE: begin
                    outLatch_d = !outLatch_q;
                end
                MODE_SET: begin
                    outLatch_d = 1'b1;
                end
                MODE_CLEAR: begin
                    outLatch_d = 1'b0;
                end
                default: begin
                    outLatch_d = outLatch_q;
                end
            endcase
        end
        if (wrCtrl && (regWrData == BYTE_ZERO)) begin
            outLatch_d = 1'b0;
        end
    end

    always_comb begin
        case (regAddr)
            REG_CTRL: begin
                rd_d = ctrl_q;
            end
            REG_CAPSRC: begin
                rd_d = {4'h0, capSel_q};
            end
            REG_HOLD_LO: begin
                rd_d = hold_q[DATA_W-1:0];
            end
            REG_HOLD_HI: begin
                rd_d = hold_q[CNT_W-1:DATA_W];
            end
            REG_FLAG: begin
                rd_d = {7'h00, flag_q};
            end
            REG_ENABLE: begin
                rd_d = {7'h00, eventEnable_q};
            end
            default: begin
                rd_d = BYTE_ZERO;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_q <= CTRL_RESET;
            capSel_q <= SRC_PIN;
            eventEnable_q <= 1'b0;
        end else begin
            if (wrCtrl) begin
                // the reserved bit keeps its old value whatever software writes
                ctrl_q <= (regWrData & CTRL_WRITABLE) | (ctrl_q & ~CTRL_WRITABLE);
            end
            if (wrCapSel) begin
                capSel_q <= regWrData[3:0];
            end
            if (wrEnable) begin
                eventEnable_q <= regWrData[0];
            end
        end
    end

    // set beats a software clear in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (captureHit || matchRise) begin
            flag_q <= 1'b1;
        end else if (wrFlag && regWrData[0]) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            srcNow_q <= 1'b0;
            srcPrev_q <= 1'b0;
            presc_q <= 4'h0;
            matchPrev_q <= 1'b0;
            hold_q <= '0;
        end else begin
            srcNow_q <= srcSelected;
            srcPrev_q <= srcNow_q;
            presc_q <= presc_d;
            matchPrev_q <= matchNow;
            hold_q <= hold_d;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            outLatch_q <= 1'b0;
            oeN_q <= 1'b1;
            trig_q <= 1'b0;
            wake_q <= 1'b0;
            rd_q <= BYTE_ZERO;
        end else begin
            outLatch_q <= outLatch_d;
            oeN_q <= ctrl_q[CTRL_DIR_BIT];
            trig_q <= matchRise && (mode == MODE_TRIGGER);
            wake_q <= link.sleepMode && flag_q && eventEnable_q;
            rd_q <= regRead ? rd_d : BYTE_ZERO;
        end
    end

    assign link.compareOut = outLatch_q;
    assign link.compareOe_n = oeN_q;
    assign link.convTrigger = trig_q;
    assign regRdData = rd_q;
    assign wakeRequest = wake_q;
endmodule : ccu_channel

// ===== rtl/ccu_pkg.sv
// package of constants and helper functions shared by both ends of the capture/compare channel
package ccu_pkg;
    localparam int CNT_W = 16;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int SRC_N = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_CAPSRC = 3'h1;
    localparam logic [ADDR_W-1:0] REG_HOLD_LO = 3'h2;
    localparam logic [ADDR_W-1:0] REG_HOLD_HI = 3'h3;
    localparam logic [ADDR_W-1:0] REG_FLAG = 3'h4;
    localparam logic [ADDR_W-1:0] REG_ENABLE = 3'h5;
    localparam int CTRL_ON_BIT = 7;
    localparam int CTRL_DIR_BIT = 5;
    localparam int CTRL_TSEL_BIT = 4;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h20;
    localparam logic [DATA_W-1:0] CTRL_WRITABLE = 8'hBF;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_SET = 4'h8;
    localparam logic [3:0] MODE_CLEAR = 4'h9;
    localparam logic [3:0] MODE_SOFT = 4'hA;
    localparam logic [3:0] MODE_TRIGGER = 4'hB;
    localparam logic [3:0] PRESC_MAX4 = 4'h3;
    localparam logic [3:0] PRESC_MAX16 = 4'hF;
    localparam logic [3:0] SRC_PIN = 4'h0;
    localparam logic [1:0] TCLK_DIV_LAST = 2'h3;
    localparam logic [1:0] TPS_1 = 2'h0;
    localparam logic [1:0] TPS_4 = 2'h1;
    localparam logic [1:0] TPS_16 = 2'h2;
    localparam logic [5:0] TPS_LAST_4 = 6'h03;
    localparam logic [5:0] TPS_LAST_16 = 6'h0F;
    localparam logic [5:0] TPS_LAST_64 = 6'h3F;
    localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

    function automatic logic isCaptureMode(input logic [3:0] m);
        isCaptureMode = (m == MODE_CAP_FALL) || (m == MODE_CAP_RISE) ||
                        (m == MODE_CAP_RISE4) || (m == MODE_CAP_RISE16);
    endfunction : isCaptureMode

    function automatic logic isCompareMode(input logic [3:0] m);
        isCompareMode = (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR) ||
                        (m == MODE_SOFT) || (m == MODE_TRIGGER);
    endfunction : isCompareMode
endpackage : ccu_pkg

// ===== rtl/ccu_link_if.sv
// interface joining the channel end and the timer/source end
`timescale 1ns/1ps
interface ccu_link_if;
    import ccu_pkg::*;
    logic [CNT_W-1:0] timerACount;
    logic [CNT_W-1:0] timerBCount;
    logic [SRC_N-1:0] capSources;
    logic pinLevel;
    logic sleepMode;
    logic compareOut;
    logic compareOe_n;
    logic convTrigger;

    modport channel (
        input timerACount, timerBCount, capSources, pinLevel, sleepMode,
        output compareOut, compareOe_n, convTrigger
    );
    modport timers (
        output timerACount, timerBCount, capSources, pinLevel, sleepMode,
        input compareOut, compareOe_n, convTrigger
    );
endinterface : ccu_link_if

// ===== rtl/ccu_timer_end.sv
// reference timers, event sources and pin model facing the channel
`timescale 1ns/1ps
module ccu_timer_end
    import ccu_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    ccu_link_if.timers link,
    input wire logic timerRun,
    input wire logic timerAExtClk,
    input wire logic timerBExtClk,
    input wire logic extLevel,
    input wire logic extClock,
    input wire logic [1:0] timerAPrescale,
    input wire logic [1:0] timerBPrescale,
    input wire logic [SRC_N-1:0] sourceLevels,
    input wire logic sleepIn,
    output logic pinObserved,
    output logic triggerSeen
);
    logic [1:0] div_q;
    logic extPrev_q;
    logic [5:0] psA_q;
    logic [5:0] psB_q;
    logic [CNT_W-1:0] cntA_q;
    logic [CNT_W-1:0] cntB_q;
    logic [SRC_N-1:0] src_q;
    logic pin_q;
    logic sleep_q;
    logic trig_q;

    // full system clock is not offered as a timer clock
    wire instrTick = (div_q == TCLK_DIV_LAST);
    wire extTick = extClock && !extPrev_q;
    // instruction-clocked timer stops in sleep, external one keeps counting
    wire tickA = timerRun && (timerAExtClk ? extTick : (instrTick && !sleepIn));
    wire tickB = timerRun && (timerBExtClk ? extTick : (instrTick && !sleepIn));
    wire [5:0] lastA = psLast(timerAPrescale);
    wire [5:0] lastB = psLast(timerBPrescale);
    wire pinLevelNow = link.compareOe_n ? extLevel : link.compareOut;

    // toggle mode needs no 1:1 here; the channel only acts on the match edge
    function automatic logic [5:0] psLast(input logic [1:0] ps);
        case (ps)
            TPS_1: psLast = 6'h00;
            TPS_4: psLast = TPS_LAST_4;
            TPS_16: psLast = TPS_LAST_16;
            default: psLast = TPS_LAST_64;
        endcase
    endfunction : psLast

    always_ff @(posedge clock) begin
        if (srst) begin
            div_q <= 2'h0;
            extPrev_q <= 1'b0;
            psA_q <= 6'h00;
            psB_q <= 6'h00;
            cntA_q <= '0;
            cntB_q <= '0;
        end else begin
            div_q <= div_q + 2'h1;
            extPrev_q <= extClock;
            if (tickA) begin
                psA_q <= (psA_q >= lastA) ? 6'h00 : psA_q + 6'h01;
                if (psA_q >= lastA) begin
                    cntA_q <= cntA_q + COUNT_ONE;
                end
            end
            if (tickB) begin
                psB_q <= (psB_q >= lastB) ? 6'h00 : psB_q + 6'h01;
                if (psB_q >= lastB) begin
                    cntB_q <= cntB_q + COUNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            src_q <= '0;
            pin_q <= 1'b0;
            sleep_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            src_q <= sourceLevels;
            pin_q <= pinLevelNow;
            sleep_q <= sleepIn;
            trig_q <= link.convTrigger;
        end
    end

    assign link.timerACount = cntA_q;
    assign link.timerBCount = cntB_q;
    assign link.capSources = src_q;
    assign link.pinLevel = pin_q;
    assign link.sleepMode = sleep_q;
    assign pinObserved = pin_q;
    assign triggerSeen = trig_q;
endmodule : ccu_timer_end

// ===== tb/ccu_link_asserts.sv
// concurrent checks on the link between the channel and the timer end
`timescale 1ns/1ps
module ccu_link_asserts
    import ccu_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [CNT_W-1:0] timerACount,
    input wire logic [CNT_W-1:0] timerBCount,
    input wire logic [SRC_N-1:0] capSources,
    input wire logic pinLevel,
    input wire logic sleepMode,
    input wire logic compareOut,
    input wire logic compareOe_n,
    input wire logic convTrigger
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    chk_reset_idle: assert property ($fell(srst) |-> !compareOut && compareOe_n && !convTrigger)
        else $error("link outputs not idle after reset");
    chk_step_timer_a: assert property ($changed(timerACount) |-> timerACount == $past(timerACount) + COUNT_ONE)
        else $error("timer A count jumped");
    chk_step_timer_b: assert property ($changed(timerBCount) |-> timerBCount == $past(timerBCount) + COUNT_ONE)
        else $error("timer B count jumped");
    // a count never moves on two edges in a row: the full clock never drives it
    chk_gap_timer_a: assert property ($changed(timerACount) |=> $stable(timerACount))
        else $error("timer A counted on consecutive edges");
    chk_gap_timer_b: assert property ($changed(timerBCount) |=> $stable(timerBCount))
        else $error("timer B counted on consecutive edges");
    chk_trigger_spacing: assert property (convTrigger |=> !convTrigger [*3])
        else $error("converter trigger repeated within one match");
    chk_trigger_no_pin: assert property (convTrigger |-> $stable(compareOut))
        else $error("trigger mode moved the output latch");
    chk_pin_follows_out: assert property (!$past(compareOe_n) |-> pinLevel == $past(compareOut))
        else $error("driven pin level not seen by capture input");

    cover property (convTrigger);
    cover property ($rose(compareOut));
    cover property (sleepMode && $changed(timerACount));
    cover property ($rose(capSources[0]));
endmodule : ccu_link_asserts

// ===== tb/ccu_test.sv
// self-checking bench joining the channel end and the timer end
`timescale 1ns/1ps
module ccu_test;
    import ccu_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic wakeRequest;
    logic extLevel = 1'b1;
    logic extClock = 1'b0;
    logic sleepIn = 1'b0;
    logic timerBExt = 1'b1;
    logic [SRC_N-1:0] sourceLevels = '0;
    logic pinObserved;
    logic triggerSeen;
    logic expOut = 1'b0;
    logic [CNT_W-1:0] expHold;
    logic [3:0] pm [2] = '{MODE_CAP_RISE4, MODE_CAP_RISE16};
    logic [3:0] cm [5] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_SOFT, MODE_TRIGGER};
    int pn [2] = '{4, 16};
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int trigCount = 0;
    int seenCount = 0;
    int expTrig = 0;
    int trigBase;
    int rises = 0;
    int seed = 84;
    int i;
    int k;

    ccu_link_if link();
    ccu_channel ccu_channel_i (.clock(clock), .srst(srst), .link(link), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .wakeRequest(wakeRequest));
    // timer A counts every extClock rise and timer B every fourth one until the last scenario, so the model can predict every count
    ccu_timer_end ccu_timer_end_i (.clock(clock), .srst(srst), .link(link), .timerRun(1'b1), .timerAExtClk(1'b1),
        .timerBExtClk(timerBExt), .extLevel(extLevel), .extClock(extClock), .timerAPrescale(TPS_1),
        .timerBPrescale(TPS_4), .sourceLevels(sourceLevels), .sleepIn(sleepIn), .pinObserved(pinObserved),
        .triggerSeen(triggerSeen));
    ccu_link_asserts ccu_link_asserts_i (.clock(clock), .srst(srst), .timerACount(link.timerACount),
        .timerBCount(link.timerBCount), .capSources(link.capSources), .pinLevel(link.pinLevel),
        .sleepMode(link.sleepMode), .compareOut(link.compareOut), .compareOe_n(link.compareOe_n),
        .convTrigger(link.convTrigger));

    always #10 clock = ~clock;

    always @(posedge clock) begin
        if (link.convTrigger === 1'b1) begin
            trigCount <= trigCount + 1;
        end
        if (triggerSeen === 1'b1) begin
            seenCount <= seenCount + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        check({8'h00, regRdData}, {8'h00, e});
    endtask : rd

    task automatic rdHold(input logic [CNT_W-1:0] e);
        rd(REG_HOLD_LO, e[7:0]);
        rd(REG_HOLD_HI, e[15:8]);
    endtask : rdHold

    task automatic pulseExt(input int n);
        repeat (n) begin
            @(posedge clock);
            extClock <= 1'b1;
            tick(3);
            extClock <= 1'b0;
            tick(3);
            rises++;
        end
    endtask : pulseExt

    // source 0 is the pin, 1..8 the on-chip sources
    task automatic setSrc(input int s, input logic v);
        @(posedge clock);
        if (s == 0) begin
            extLevel <= v;
        end else begin
            sourceLevels[s-1] <= v;
        end
        tick(6);
    endtask : setSrc

    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        wr(3'h6, 8'h5A);
        for (i = 0; i < 8; i++) begin
            rd(ADDR_W'(i), (i == 0) ? CTRL_RESET : BYTE_ZERO);
        end
        for (i = 0; i <= SRC_N; i++) begin
            setSrc(i, 1'b0);
            wr(REG_CAPSRC, DATA_W'(i));
            wr(REG_CTRL, 8'hA5);
            wr(REG_FLAG, 8'h01);
            setSrc(i, 1'b1);
            k = 1 + ($unsigned($random(seed)) % 4);
            pulseExt(k);
            setSrc(i, 1'b0);
            setSrc(i, 1'b1);
            rdHold(CNT_W'(rises));
            rd(REG_FLAG, 8'h01);
            wr(REG_FLAG, 8'h01);
            rd(REG_FLAG, 8'h00);
        end
        wr(REG_CAPSRC, 8'h01);
        wr(REG_CTRL, 8'hB4);
        pulseExt(8);
        wr(REG_FLAG, 8'h01);
        setSrc(1, 1'b0);
        rdHold(CNT_W'(rises / 4));
        wr(REG_FLAG, 8'h01);
        setSrc(1, 1'b1);
        rd(REG_FLAG, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr(REG_CTRL, {4'hA, pm[i]});
            setSrc(1, 1'b0);
            setSrc(1, 1'b1);
            setSrc(1, 1'b0);
            setSrc(1, 1'b1);
            // clearing first must drop the two rises already counted
            wr(REG_CTRL, BYTE_ZERO);
            wr(REG_CTRL, {4'hA, pm[i]});
            wr(REG_FLAG, 8'h01);
            for (k = 1; k <= pn[i]; k++) begin
                setSrc(1, 1'b0);
                pulseExt(1);
                setSrc(1, 1'b1);
                if (k == pn[i] - 1) begin
                    rd(REG_FLAG, 8'h00);
                end
            end
            rdHold(CNT_W'(rises));
        end
        setSrc(0, 1'b1);
        wr(REG_CAPSRC, BYTE_ZERO);
        wr(REG_CTRL, 8'hA4);
        wr(REG_FLAG, 8'h01);
        wr(REG_CTRL, 8'h84);
        tick(6);
        check(pinObserved, 1'b0);
        rd(REG_FLAG, 8'h01);
        rdHold(CNT_W'(rises));
        for (i = 0; i < 5; i++) begin
            expHold = CNT_W'(rises + 2);
            wr(REG_HOLD_LO, expHold[7:0]);
            wr(REG_HOLD_HI, expHold[15:8]);
            wr(REG_CTRL, {4'h8, cm[i]});
            wr(REG_FLAG, 8'h01);
            trigBase = trigCount;
            pulseExt(3);
            expOut = (cm[i] == MODE_SET) ? 1'b1 : (cm[i] == MODE_CLEAR) ? 1'b0 :
                     (cm[i] == MODE_TOGGLE) ? !expOut : expOut;
            check(link.compareOut, expOut);
            check(CNT_W'(trigCount - trigBase), (cm[i] == MODE_TRIGGER) ? COUNT_ONE : '0);
            expTrig = expTrig + ((cm[i] == MODE_TRIGGER) ? 1 : 0);
            check(CNT_W'(seenCount), CNT_W'(expTrig));
            rd(REG_FLAG, 8'h01);
        end
        wr(REG_CTRL, BYTE_ZERO);
        tick(2);
        check(link.compareOut, 1'b0);
        wr(REG_FLAG, 8'h01);
        wr(REG_ENABLE, 8'h01);
        sleepIn <= 1'b1;
        expHold = CNT_W'(rises + 2);
        wr(REG_HOLD_LO, expHold[7:0]);
        wr(REG_HOLD_HI, expHold[15:8]);
        wr(REG_CTRL, 8'h8A);
        pulseExt(3);
        check(wakeRequest, 1'b1);
        rd(REG_FLAG, 8'h01);
        tick(1);
        sleepIn <= 1'b0;
        tick(3);
        check(wakeRequest, 1'b0);
        // an instruction-clocked timer must freeze in sleep and resume after it
        timerBExt <= 1'b0;
        sleepIn <= 1'b1;
        tick(2);
        expHold = link.timerBCount;
        tick(40);
        check(link.timerBCount, expHold);
        sleepIn <= 1'b0;
        tick(40);
        check(CNT_W'(link.timerBCount != expHold), COUNT_ONE);
        print_verdict();
    end
endmodule : ccu_test
